/* common/rtb_defines.svh */
// Operation
// RULE_01: fine mode corrects the time base once per minute
// RULE_02: each step adds or removes two cycles
// RULE_03: zero step count disables trimming entirely
// RULE_04: direction bit selects adding or removing cycles
// RULE_05: host sets direction when oscillator runs slow
// RULE_06: trimming keeps running on backup supply
// RULE_07: coarse mode corrects once every second
// RULE_08: coarse plus square wave gives trimmed 1 Hz
// RULE_09: coarse 1 Hz output off on backup
// RULE_10: host leaves coarse mode off normally
// RULE_11: host frequency calibration sequence with zero trim
// RULE_12: host trim from measured frequency formula
// RULE_13: host trim from ppm drift formula
// RULE_14: switch to backup below threshold, back above
// RULE_15: host sets backup enable before losing power
// RULE_16: backup keeps time, drops serial and square wave
// RULE_17: power loss and return capture timestamps, flag
// RULE_18: no new timestamps while loss flag set
// RULE_19: clearing loss flag clears all timestamps
// RULE_20: host starts oscillator, waits running, enables backup
// RULE_21: trim register at 0x09, cleared at reset
// RULE_22: every divided rate trimmed, undivided rate not
// RULE_23: timestamp month carries weekday in bits 7-5
// RULE_24: adding shortens second, removing lengthens it
// RULE_25: correction sits in divider feeding seconds
`ifndef RTB_DEFINES_SVH
`define RTB_DEFINES_SVH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define RTB_ADDR_START 8'h00
`define RTB_ADDR_HOUR  8'h02
`define RTB_ADDR_WEEKDAY_FIELD 8'h03
`define RTB_ADDR_CTRL  8'h08
`define RTB_ADDR_TRIM  8'h09
`define RTB_TS_PAGE    5'h03

// ----------------------------------------
// field positions
// ----------------------------------------
`define RTB_START_BIT  7
`define RTB_DIR_BIT    7
`define RTB_RUN_BIT    5
`define RTB_FLAG_BIT   4
`define RTB_BATEN_BIT  3
`define RTB_SQUARE_WAVE_ENABLE_BIT  6
`define RTB_EXTERNAL_CLOCK_INPUT_ENABLE_BIT 3
`define RTB_COARSE_BIT 2

// ----------------------------------------
// values and counts
// ----------------------------------------
`define RTB_DIV_NOMINAL 16'h7fff
`define RTB_DIV_HALF    16'h4000
`define RTB_LAST_SEC    6'h3b
`define RTB_TRIM_OFF    8'h00
`define RTB_RATE_UNDIV  2'h0
`define RTB_RATE_DIV4   2'h1
`define RTB_RATE_DIV8   2'h2
`define RTB_RATE_1HZ    2'h3
`define RTB_CTRL_TOP    1'b1

`endif

/* common/rtb_pkg.sv */
`default_nettype none
package rtb_pkg;
   // whole block state, registered once per clock
   typedef struct packed {
      logic [2:0]      osc_sync;    // time base pin synchroniser
      logic            osc_lvl;     // filtered time base level
      logic [2:0]      vcc_sync;    // threshold pin synchroniser
      logic            vcc_lvl;     // filtered below-threshold level
      logic [15:0]     div_cnt;     // time base cycles in this second
      logic [5:0]      sec_in_min;  // seconds within the minute
      logic            second_tick; // trimmed one second pulse
      logic            sqw_out;     // square wave output
      logic [6:0]      ctrl;        // control bits 6..0
      logic [7:0]      trim;        // trim step count
      logic            trim_dir;    // 1 adds cycles
      logic            start_bit;   // oscillator start
      logic            bat_en;      // backup supply enable
      logic            pwr_flag;    // power loss flag
      logic            osc_run;     // oscillator running flag
      logic            up_pending;  // power-up stamp still owed
      logic            on_backup;   // running from backup
      logic [7:0][7:0] ts;          // 3..0 down set, 7..4 up set
      logic [7:0]      rdata;       // read data
   } rtb_state_s;
endpackage : rtb_pkg
`default_nettype wire

/* logic/rtb_trim_backup.sv */
`timescale 1ns/1ns
`default_nettype none
`include "rtb_defines.svh"
module rtb_trim_backup
   import rtb_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   input  wire logic       osc_clk_pin,      // 32.768 kHz time base
   input  wire logic       vcc_below_trip,   // supply comparator pin
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   input  wire logic [6:0] cur_minutes,
   input  wire logic [6:0] cur_hours,
   input  wire logic [5:0] cur_date,
   input  wire logic [4:0] cur_month,
   input  wire logic [2:0] cur_weekday,
   output logic            second_tick,
   output logic            clock_output_pin,
   output logic            on_backup,
   output logic            oscillator_running_flag
);

   // ----------------------------------------
   // state and derived terms
   // ----------------------------------------
   rtb_state_s  st;          // registered state
   rtb_state_s  nx;          // next state
   logic        osc_rise;    // agreed rising edge of time base
   logic        osc_on;      // start bit or external input
   logic        corr;        // this second carries a correction
   logic [15:0] step2;       // two cycles per step
   logic [15:0] term;        // last count of this second
   logic        acc_ok;      // serial access alive

   // edge counts only once second and third stages agree
   assign osc_rise = (st.osc_sync[2] == st.osc_sync[1]) && st.osc_sync[2] && !st.osc_lvl;
   assign osc_on   = st.start_bit | st.ctrl[`RTB_EXTERNAL_CLOCK_INPUT_ENABLE_BIT];
   // per second in coarse mode, else last second of minute
   assign corr     = st.ctrl[`RTB_COARSE_BIT] || (st.sec_in_min == `RTB_LAST_SEC); // [RULE_01] [RULE_07]
   assign step2    = {7'h00, st.trim, 1'b0}; // [RULE_02]
   // adding shortens the second, removing stretches it
   always_comb begin
      term = `RTB_DIV_NOMINAL;
      if (corr && st.trim != `RTB_TRIM_OFF) begin // [RULE_03]
         if (st.trim_dir) begin // [RULE_04]
            term = `RTB_DIV_NOMINAL - step2; // [RULE_24]
         end else begin
            term = `RTB_DIV_NOMINAL + step2; // [RULE_24]
         end
      end
   end
   // serial side is dead on backup
   assign acc_ok = !st.on_backup; // [RULE_16]

   // stamp of the current calendar, weekday above month
   function automatic logic [3:0][7:0] stamp(input logic [6:0] mi, input logic [6:0] hr,
                                            input logic [5:0] dt, input logic [4:0] mo,
                                            input logic [2:0] wd);
      stamp = {{wd, mo}, {2'h0, dt}, {1'b0, hr}, {1'b0, mi}}; // [RULE_23]
   endfunction : stamp

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      nx             = st;
      nx.second_tick = 1'b0;
      // three stage synchronisers, first stage feeds only the second
      nx.osc_sync = {st.osc_sync[1:0], osc_clk_pin};
      nx.vcc_sync = {st.vcc_sync[1:0], vcc_below_trip};
      if (st.osc_sync[2] == st.osc_sync[1]) begin
         nx.osc_lvl = st.osc_sync[2];
      end
      if (st.vcc_sync[2] == st.vcc_sync[1]) begin
         nx.vcc_lvl = st.vcc_sync[2];
      end
      // trimmed divider, runs on backup too; >= absorbs trim changes mid-second
      if (osc_on && osc_rise) begin // [RULE_06]
         if (st.div_cnt >= term) begin // [RULE_25]
            nx.div_cnt     = 16'h0000;
            nx.second_tick = 1'b1;
            nx.sec_in_min  = (st.sec_in_min == `RTB_LAST_SEC) ? 6'h00 : st.sec_in_min + 6'h01;
         end else begin
            nx.div_cnt = st.div_cnt + 16'h0001;
         end
      end
      // running flag needs a seen edge while enabled
      nx.osc_run = osc_on && (st.osc_run || osc_rise);
      // supply switch follows the threshold level
      nx.on_backup = st.vcc_lvl && st.bat_en; // [RULE_14]
      // register writes, ignored while on backup
      if (reg_wr && acc_ok) begin
         case (reg_addr)
            `RTB_ADDR_START: begin
               nx.start_bit = reg_wdata[`RTB_START_BIT];
            end
            `RTB_ADDR_HOUR: begin
               nx.trim_dir = reg_wdata[`RTB_DIR_BIT];
            end
            `RTB_ADDR_WEEKDAY_FIELD: begin
               nx.bat_en = reg_wdata[`RTB_BATEN_BIT];
               // writing zero clears flag and every stamp
               if (!reg_wdata[`RTB_FLAG_BIT]) begin
                  nx.pwr_flag   = 1'b0;
                  nx.ts         = '0; // [RULE_19]
                  nx.up_pending = 1'b0;
               end
            end
            `RTB_ADDR_CTRL: begin
               nx.ctrl = reg_wdata[6:0];
            end
            `RTB_ADDR_TRIM: begin
               nx.trim = reg_wdata; // [RULE_21]
            end
            default: begin
               if (reg_addr[7:3] == `RTB_TS_PAGE) begin
                  nx.ts[reg_addr[2:0]] = reg_wdata;
               end
            end
         endcase
      end
      // power events come after writes so a capture wins over a clear
      if (nx.on_backup && !st.on_backup && !st.pwr_flag) begin // [RULE_18]
         nx.ts[3:0]    = stamp(cur_minutes, cur_hours, cur_date, cur_month, cur_weekday); // [RULE_17]
         nx.pwr_flag   = 1'b1;
         nx.up_pending = 1'b1;
      end
      // return stamp only belongs to a logged loss
      if (!nx.on_backup && st.on_backup && st.up_pending) begin
         nx.ts[7:4]    = stamp(cur_minutes, cur_hours, cur_date, cur_month, cur_weekday); // [RULE_17]
         nx.up_pending = 1'b0;
      end
      // square wave, silent on backup
      nx.sqw_out = 1'b0;
      if (st.ctrl[`RTB_SQUARE_WAVE_ENABLE_BIT] && !st.on_backup) begin // [RULE_09] [RULE_16]
         if (st.ctrl[`RTB_COARSE_BIT]) begin
            nx.sqw_out = st.div_cnt < `RTB_DIV_HALF; // [RULE_08]
         end else begin
            case (st.ctrl[1:0])
               `RTB_RATE_UNDIV: nx.sqw_out = st.osc_lvl; // [RULE_22]
               `RTB_RATE_DIV4:  nx.sqw_out = st.div_cnt[1]; // [RULE_22]
               `RTB_RATE_DIV8:  nx.sqw_out = st.div_cnt[2]; // [RULE_22]
               default:         nx.sqw_out = st.div_cnt < `RTB_DIV_HALF;
            endcase
         end
      end
      // read data, zero for unmapped or while on backup
      nx.rdata = 8'h00;
      if (reg_rd && acc_ok) begin
         case (reg_addr)
            `RTB_ADDR_START: nx.rdata = {st.start_bit, 7'h00};
            `RTB_ADDR_HOUR:  nx.rdata = {st.trim_dir, cur_hours};
            `RTB_ADDR_WEEKDAY_FIELD: nx.rdata = {2'h0, st.osc_run, st.pwr_flag, st.bat_en, cur_weekday};
            `RTB_ADDR_CTRL:  nx.rdata = {`RTB_CTRL_TOP, st.ctrl};
            `RTB_ADDR_TRIM:  nx.rdata = st.trim;
            default: begin
               if (reg_addr[7:3] == `RTB_TS_PAGE) begin
                  nx.rdata = st.ts[reg_addr[2:0]];
               end
            end
         endcase
      end
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0; // [RULE_21]
      end else begin
         st <= nx;
      end
   end

   assign reg_rdata               = st.rdata;
   assign second_tick             = st.second_tick;
   assign clock_output_pin        = st.sqw_out;
   assign on_backup               = st.on_backup;
   assign oscillator_running_flag = st.osc_run;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   a_tick_pulse: assert property (st.second_tick |=> !st.second_tick) // [RULE_25]
      else $error("second tick longer than one cycle");
   a_minute_once: assert property (!st.ctrl[`RTB_COARSE_BIT] && corr |-> st.sec_in_min == `RTB_LAST_SEC) // [RULE_01]
      else $error("fine correction outside last second");
   a_coarse_each: assert property (st.ctrl[`RTB_COARSE_BIT] |-> corr) // [RULE_07]
      else $error("coarse mode skipped a correction");
   a_trim_off_len: assert property (st.second_tick && $past(st.trim) == `RTB_TRIM_OFF // [RULE_03]
      && $past(st.trim, 2) == `RTB_TRIM_OFF |-> $past(st.div_cnt) == `RTB_DIV_NOMINAL)
      else $error("zero trim changed second length");
   a_add_short: assert property (st.second_tick && $past(corr) && $past(st.trim_dir) // [RULE_24]
      && $past(st.trim) == $past(st.trim, 2) |-> $past(st.div_cnt) == `RTB_DIV_NOMINAL - $past(step2))
      else $error("added cycles did not shorten second");
   a_remove_long: assert property (st.second_tick && $past(corr) && !$past(st.trim_dir) // [RULE_04]
      && $past(st.trim) == $past(st.trim, 2) |-> $past(st.div_cnt) == `RTB_DIV_NOMINAL + $past(step2))
      else $error("removed cycles did not lengthen second");
   a_sqw_backup: assert property ($past(st.on_backup) |-> !st.sqw_out) // [RULE_09]
      else $error("square wave active on backup");
   a_coarse_hz: assert property ($past(st.ctrl[`RTB_SQUARE_WAVE_ENABLE_BIT] && st.ctrl[`RTB_COARSE_BIT] && !st.on_backup) // [RULE_08]
      |-> st.sqw_out == ($past(st.div_cnt) < `RTB_DIV_HALF))
      else $error("coarse output not the trimmed 1 Hz");
   a_switch_follow: assert property (st.on_backup == $past(st.vcc_lvl && st.bat_en)) // [RULE_14]
      else $error("supply switch not following threshold");
   a_down_log: assert property ($rose(st.on_backup) && !$past(st.pwr_flag) // [RULE_17]
      |-> st.pwr_flag && st.ts[0] == {1'b0, $past(cur_minutes)})
      else $error("loss did not log minutes and flag");
   // the owed return stamp of a logged loss and any register write are the changes allowed while flagged
   a_no_log_flag: assert property ($past(st.pwr_flag) && st.pwr_flag && !$past(reg_wr) && !$past(st.up_pending) // [RULE_18]
      |-> $stable(st.ts))
      else $error("stamps changed while flag set");
   a_flag_clear: assert property ($fell(st.pwr_flag) |-> st.ts == '0) // [RULE_19]
      else $error("flag clear left stamps");

   c_coarse_tick: cover property (st.ctrl[`RTB_COARSE_BIT] && st.second_tick);
   c_add_tick:    cover property (st.second_tick && $past(corr) && $past(st.trim_dir) && $past(st.trim) != 8'h00);
   c_down_log:    cover property ($rose(st.on_backup) && !$past(st.pwr_flag));
   c_up_log:      cover property ($fell(st.on_backup) && $past(st.up_pending));

endmodule : rtb_trim_backup
`default_nettype wire

/* sim/rtb_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// host side of the register port
// ----------------------------------------
module rtb_host_model (
   input  wire logic       sys_clk,
   output logic            reg_wr,
   output logic            reg_rd,
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata,
   input  wire logic [7:0] reg_rdata
);
   // idle strobes from time zero
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   // one write; strobe up for one rising edge only
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge sys_clk);
      reg_wr = 1'b0;
      reg_addr = ~a;     // released lines never keep the old value
      reg_wdata = ~d;
   endtask : wr
   // one read; data stands the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge sys_clk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge sys_clk);
      d = reg_rdata;
      reg_rd = 1'b0;
      reg_addr = ~a;
   endtask : rd
endmodule : rtb_host_model
`default_nettype wire

/* sim/test_rtb_trim_and_backup.sv */
`timescale 1ns/1ns
`default_nettype none
module test_rtb_trim_and_backup;
   localparam int unsigned SEC = 32768; // time base edges per second
   localparam int unsigned N   = (6 * 32768 * 60) / (1000000 * 2); // 6 ppm slow drift, 5 steps
   localparam int unsigned NF  = ((32769 - 32768) * 60) / 2;       // 1 Hz fast at undivided rate
   logic        sys_clk, rst_n, osc, vcc, tick, clk_out, bak, run;
   logic        reg_wr, reg_rd;
   logic  [7:0] reg_addr, reg_wdata, reg_rdata, got;
   logic [27:0] cal;                    // minutes, hours, date, month, weekday
   int          bad_count = 0;
   int          check_count = 0;
   int          n;
   // one row: write flag, address, write data, expected read
   logic [24:0] rows [13] = '{25'h0090000, 25'h0080080, 25'h0030005,
      25'h01c0000, 25'h109ffff, 25'h100ff80, 25'h1405a00, 25'h11ca5a5,
      25'h10280a3, 25'h103082d, 25'h1087fff, 25'h1080080, 25'h1090505};
   logic  [7:0] stamp [8] = '{8'h45, 8'h23, 8'h31, 8'hb2, 8'h46, 8'h01, 8'h02, 8'hc1};

   rtb_host_model host (.sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
   rtb_trim_backup dut (.sys_clk(sys_clk), .rst_n(rst_n), .osc_clk_pin(osc),
      .vcc_below_trip(vcc), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cur_minutes(cal[27:21]),
      .cur_hours(cal[20:14]), .cur_date(cal[13:8]), .cur_month(cal[7:3]),
      .cur_weekday(cal[2:0]), .second_tick(tick), .clock_output_pin(clk_out),
      .on_backup(bak), .oscillator_running_flag(run));

   // ----------------------------------------
   // clocks: 4 ns system, time base sped up to 4 cycles per edge
   // ----------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   // shortest period the pin filter still accepts, keeps seconds short
   initial begin
      osc = 1'b0;
      forever begin
         repeat (2) @(negedge sys_clk);
         osc = ~osc;
      end
   end

   // ----------------------------------------
   // compares and verdict
   // ----------------------------------------
   task automatic chk8(input logic [7:0] g, input logic [7:0] e);
      check_count++;
      if (g !== e) begin
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
         bad_count++;
      end
   endtask : chk8
   task automatic chk32(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
         bad_count++;
      end
   endtask : chk32
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      host.rd(a, got);
      chk8(got, e);
   endtask : rdc
   // length of the next whole second, in time base edges
   task automatic meas(input logic [31:0] e);
      n = 0;
      do @(negedge sys_clk); while (tick !== 1'b1 && ++n < 300000);
      n = 0;
      do begin
         @(negedge sys_clk);
         n++;
      end while (tick !== 1'b1 && n < 300000);
      chk32(n, e * 4);
   endtask : meas
   task automatic finish_test;
      if (bad_count == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : finish_test

   // watchdog: about eight seconds of trimmed time plus margin
   initial begin
      #10_000_000;
      bad_count++;
      finish_test();
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      rst_n = 1'b0;
      vcc = 1'b0;
      cal = {7'h45, 7'h23, 6'h31, 5'h12, 3'h5};
      repeat (4) @(negedge sys_clk);
      rst_n = 1'b1;
      // reset values, then map; backup enable only once running
      for (int i = 0; i < 13; i++) begin
         if (rows[i][24])
            host.wr(rows[i][23:16], rows[i][15:8]);
         rdc(rows[i][23:16], rows[i][7:0]);
      end
      meas(SEC);
      host.wr(8'h08, 8'h04);
      meas(SEC - 2 * N);
      host.wr(8'h09, 8'h00);
      host.wr(8'h08, 8'h46);
      meas(SEC);
      repeat (8) @(negedge sys_clk);
      chk8({7'h0, clk_out}, 8'h01);
      // fine mode 1 Hz rate, early in the second so still high
      host.wr(8'h08, 8'h43);
      repeat (4) @(negedge sys_clk);
      chk8({7'h0, clk_out}, 8'h01);
      host.wr(8'h08, 8'h46);
      // fast oscillator: direction cleared, removing cycles lengthens
      host.wr(8'h02, 8'h00);
      host.wr(8'h09, NF[7:0]);
      vcc = 1'b1;
      repeat (10) @(negedge sys_clk);
      chk8({7'h0, bak}, 8'h01);
      rdc(8'h09, 8'h00);
      meas(SEC + 2 * NF);
      chk8({7'h0, clk_out}, 8'h00);
      cal = {7'h46, 7'h01, 6'h02, 5'h01, 3'h6};
      vcc = 1'b0;
      repeat (10) @(negedge sys_clk);
      chk8({7'h0, bak}, 8'h00);
      for (int i = 0; i < 8; i++)
         rdc(8'h18 + i[7:0], stamp[i]);
      rdc(8'h03, 8'h3e);
      // second outage with flag still set must not overwrite
      cal = 28'h0;
      vcc = 1'b1;
      repeat (10) @(negedge sys_clk);
      vcc = 1'b0;
      repeat (10) @(negedge sys_clk);
      rdc(8'h18, 8'h45);
      rdc(8'h1c, 8'h46);
      host.wr(8'h03, 8'h08);
      rdc(8'h18, 8'h00);
      rdc(8'h1f, 8'h00);
      host.wr(8'h08, 8'h00);
      finish_test();
   end
endmodule : test_rtb_trim_and_backup
`default_nettype wire
